// file: src/acqms_params.svh
// Constants for the acquisition channel and mode control block.
// Assumes a 100 MHz system clock and byte addressing on the register bus.
`ifndef ACQMS_PARAMS_SVH
`define ACQMS_PARAMS_SVH

// Register byte offsets
`define ACQMS_OFF_CONFIG     4'h0
`define ACQMS_OFF_CONTROL    4'h4
`define ACQMS_OFF_STATUS     4'h8
`define ACQMS_OFF_RESULT     4'hC

// Configuration field positions and reset value
`define ACQMS_CFG_CODE_LSB   0
`define ACQMS_CFG_PAIR_BIT   3
`define ACQMS_CFG_SIGNED_BIT 4
`define ACQMS_CFG_UBE_BIT    5
`define ACQMS_CFG_ROM_BIT    6
`define ACQMS_CFG_RESET      7'h00

// Control and status field positions
`define ACQMS_CTL_START_BIT  0
`define ACQMS_ST_BUSY_BIT    0
`define ACQMS_ST_VALID_BIT   1
`define ACQMS_ST_MODE_LSB    2
`define ACQMS_ST_READY_BIT   4

// Timing
`define ACQMS_CLK_MHZ        100
`define ACQMS_CONV_EDGES     16
`define ACQMS_ASYNC_CONV_NS  7500
`define ACQMS_ASYNC_CONV_CYC ((`ACQMS_ASYNC_CONV_NS * `ACQMS_CLK_MHZ + 999) / 1000)

`endif

// file: src/acqms_pkg.sv
// Types shared by the acquisition channel and mode control block.
// Assumes nothing beyond a SystemVerilog compiler.
package acqms_pkg;

    // Level seen on the three-level interface mode pin
    typedef enum logic [1:0] {
        ACQMS_MODE_LOW  = 2'b00,
        ACQMS_MODE_HIGH = 2'b01,
        ACQMS_MODE_OPEN = 2'b10
    } acqms_mode_t;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ACQMS_ST_IDLE  = 2'b00,
        ACQMS_ST_SYNC  = 2'b01,
        ACQMS_ST_ASYNC = 2'b10
    } acqms_state_t;

endpackage

// file: src/acqms_sel_if.sv
// Channel selection bundle between control logic and selector decoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
interface acqms_sel_if;
    logic [2:0] code;       // Channel code, bit 2 most significant
    logic       pair;       // Pair input select
    logic [7:0] pos;        // Input switched to positive side
    logic [7:0] neg;        // Input switched to negative side
    logic       com_pos;    // Common return on positive side
    logic       com_neg;    // Common return on negative side
    logic       selout_gnd; // Selector output tied to analog ground

    modport decode (input code, input pair, output pos, output neg,
                    output com_pos, output com_neg, output selout_gnd);
    modport ctrl (output code, output pair, input pos, input neg,
                  input com_pos, input com_neg, input selout_gnd);
endinterface

// file: src/acqms_chan_decode.sv
// Analog selector decoder: channel code and pairing to switch map.
// Assumes the code and pair bits are stable flops from the control side.
`timescale 1ns/100ps
module acqms_chan_decode #(
    parameter bit HAS_SELOUT = 1'b0
) (
    input  wire logic     clk,
    input  wire logic     rst_n,
    acqms_sel_if.decode   sel
);

    // Top two codes, claimed by the selector output on that variant
    wire top_codes = sel.code[2] & sel.code[1];
    wire on_selout = HAS_SELOUT & top_codes;

    // Switch map
    always_comb begin
        sel.pos        = 8'h00;
        sel.neg        = 8'h00;
        sel.com_pos    = 1'b0;
        sel.com_neg    = 1'b0;
        sel.selout_gnd = 1'b0;
        if (on_selout) begin
            // Code 110 grounds the output, 111 leaves it open; the negative common return is on for both
            sel.selout_gnd = ~sel.code[0];
            sel.com_pos    = ~sel.code[0];
            sel.com_neg    = 1'b1;
        end else if (!sel.pair) begin
            // One input against the common return
            sel.pos[sel.code] = 1'b1;
            sel.com_neg       = 1'b1;
        end else begin
            // Even code: lower input positive; odd: lower negative
            sel.pos[sel.code]        = 1'b1;
            sel.neg[sel.code ^ 3'h1] = 1'b1;
        end
    end

    single_ended_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!sel.pair && !top_codes) |-> (sel.pos == (8'h01 << sel.code)) && sel.com_neg && sel.neg == 8'h00)
        else $error("single-ended map wrong");
    pair_polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sel.pair && !on_selout) |-> (sel.pos == (8'h01 << sel.code))
            && (sel.neg == (8'h01 << (sel.code ^ 3'h1))) && !sel.com_neg)
        else $error("pair polarity wrong");
    upper_inputs_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!HAS_SELOUT && top_codes) |-> sel.pos[sel.code] && !sel.selout_gnd)
        else $error("inputs 6 and 7 not selected");
    selout_ground_a: assert property (@(posedge clk) disable iff (!rst_n)
        (HAS_SELOUT && sel.code == 3'h6) |-> sel.selout_gnd && sel.pos == 8'h00 && sel.neg == 8'h00)
        else $error("selector output not grounded");
    selout_open_a: assert property (@(posedge clk) disable iff (!rst_n)
        (HAS_SELOUT && sel.code == 3'h7) |-> !sel.selout_gnd && sel.pos == 8'h00 && sel.neg == 8'h00)
        else $error("selector output not open");

endmodule

// file: src/acqms_top.sv
// Acquisition channel and mode control: Avalon-MM slave, selector
// control, conversion sequencer and result presentation.
// Assumes all inputs synchronous to CLK; the converter core is outside.
`timescale 1ns/100ps
`include "acqms_params.svh"
module acqms_top #(
    parameter bit HAS_SELOUT   = 1'b0,
    parameter int ASYNC_CYCLES = `ACQMS_ASYNC_CONV_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic [1:0]  MODE_LEVEL,
    input  wire logic        CONVERSION_CLOCK_IN,
    input  wire logic [11:0] CONV_CODE_IN,
    output logic      [7:0]  AIN_POS_EN,
    output logic      [7:0]  AIN_NEG_EN,
    output logic             COMMON_POS_EN,
    output logic             COMMON_NEG_EN,
    output logic             SELOUT_GND_EN,
    output logic             RANGE_BIPOLAR,
    output logic             HOLD,
    output logic             BUSY_N,
    output logic             READY_O,
    output logic             READY_OE,
    output logic      [11:0] RESULT_BUS_O,
    output logic             RESULT_BUS_OE
);

    localparam int CNT_W = 10;

    // Counter end values, sized to the counter
    localparam logic [CNT_W-1:0] SYNC_LAST  = CNT_W'(`ACQMS_CONV_EDGES - 1);
    localparam logic [CNT_W-1:0] ASYNC_LAST = CNT_W'(ASYNC_CYCLES - 1);

    acqms_sel_if sel ();

    // Storage
    logic [6:0]              cfg;         // Configuration register
    logic [11:0]             result;      // Last conversion result
    logic                    result_valid; // Fresh result not yet read
    logic                    ack;         // Bus answer strobe
    logic                    slow_wait;   // Slow read awaits conversion
    logic                    conv_prev;   // Conversion clock last sample
    logic [CNT_W-1:0]        cnt;         // Edge or cycle counter
    acqms_pkg::acqms_state_t state;       // Sequencer state
    acqms_pkg::acqms_state_t next_state;  // Sequencer next state
    logic [CNT_W-1:0]        next_cnt;    // Counter next value

    // Mode pin decode; the unused code reads as open, the safe default
    acqms_pkg::acqms_mode_t mode;
    assign mode = (MODE_LEVEL == 2'b11) ? acqms_pkg::ACQMS_MODE_OPEN
                                        : acqms_pkg::acqms_mode_t'(MODE_LEVEL);
    wire mode_low  = (mode == acqms_pkg::ACQMS_MODE_LOW);
    wire mode_high = (mode == acqms_pkg::ACQMS_MODE_HIGH);
    wire mode_open = (mode == acqms_pkg::ACQMS_MODE_OPEN);

    // Configuration fields
    wire [2:0] chan_code = cfg[`ACQMS_CFG_CODE_LSB +: 3];
    wire       pair_sel  = cfg[`ACQMS_CFG_PAIR_BIT];
    wire       ube       = cfg[`ACQMS_CFG_UBE_BIT];
    wire       rom_mode  = cfg[`ACQMS_CFG_ROM_BIT];

    // Bus decode
    wire req      = AVS_READ | AVS_WRITE;
    wire hit_cfg  = (AVS_ADDRESS == `ACQMS_OFF_CONFIG);
    wire hit_ctl  = (AVS_ADDRESS == `ACQMS_OFF_CONTROL);
    wire hit_st   = (AVS_ADDRESS == `ACQMS_OFF_STATUS);
    wire hit_res  = (AVS_ADDRESS == `ACQMS_OFF_RESULT);
    wire res_rd   = AVS_READ & hit_res;
    wire slow_rd  = res_rd & mode_low & ~rom_mode;
    wire idle     = (state == acqms_pkg::ACQMS_ST_IDLE);

    // Answer: one wait cycle, or until the slow read's result lands
    wire next_ack = req & ~ack & (~slow_rd | (slow_wait & idle));
    // Writes land on the edge the master sees waitrequest low; read data
    // must already stand by then, so reads are fetched one edge earlier
    wire wr_take  = AVS_WRITE & ack;
    wire rd_take  = AVS_READ & next_ack;

    // Conversion start sources per interface mode
    wire port_start = wr_take & hit_ctl & AVS_BYTEENABLE[0]
                      & AVS_WRITEDATA[`ACQMS_CTL_START_BIT] & ~mode_low;
    wire rom_start  = rd_take & hit_res & mode_low & rom_mode;
    wire slow_start = slow_rd & ~slow_wait & ~ack;
    wire start      = idle & (port_start | rom_start | slow_start);

    // Conversion clock edge, input already synchronous
    wire conv_rise = CONVERSION_CLOCK_IN & ~conv_prev;

    // Sequencer end of conversion
    wire done = ((state == acqms_pkg::ACQMS_ST_SYNC) & conv_rise & (cnt == SYNC_LAST))
              | ((state == acqms_pkg::ACQMS_ST_ASYNC) & (cnt == ASYNC_LAST));

    // Result presentation: whole word or upper nibble on low lines
    wire [11:0] res_view = ube ? {8'h00, result[11:8]} : result;

    // Status word
    wire [31:0] status_word = {27'h0000000, READY_O, MODE_LEVEL,
                               result_valid, ~idle};

    // Read data select; control reads as zero
    wire [31:0] rd_mux = hit_cfg ? {25'h0000000, cfg}
                       : hit_st  ? status_word
                       : hit_res ? {20'h00000, res_view}
                       : 32'h00000000;

    // Sequencer next state
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            acqms_pkg::ACQMS_ST_IDLE: begin
                next_cnt = '0;
                if (start && mode_open) begin
                    // Free-running timing, independent of host and clock pin
                    next_state = acqms_pkg::ACQMS_ST_ASYNC;
                end else if (start) begin
                    next_state = acqms_pkg::ACQMS_ST_SYNC;
                end
            end
            acqms_pkg::ACQMS_ST_SYNC: begin
                // Start lands mid-period, so 16 edges span 15 to 16 periods
                if (done) begin
                    next_state = acqms_pkg::ACQMS_ST_IDLE;
                end else if (conv_rise) begin
                    next_cnt = cnt + 1'b1;
                end
            end
            acqms_pkg::ACQMS_ST_ASYNC: begin
                if (done) begin
                    next_state = acqms_pkg::ACQMS_ST_IDLE;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            default: begin
                // Unused code recovers to idle
                next_state = acqms_pkg::ACQMS_ST_IDLE;
            end
        endcase
    end

    // Sequencer flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state     <= acqms_pkg::ACQMS_ST_IDLE;
            cnt       <= '0;
            conv_prev <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            conv_prev <= CONVERSION_CLOCK_IN;
        end
    end

    // Result capture at end of conversion
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            result <= 12'h000;
        end else if (done) begin
            result <= CONV_CODE_IN;
        end
    end

    // Fresh-result flag; a landing result beats the read that clears it
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            result_valid <= 1'b0;
        end else if (done) begin
            result_valid <= 1'b1;
        end else if (rd_take && hit_res) begin
            result_valid <= 1'b0;
        end
    end

    // Slow-read wait flag, held until the answer
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            slow_wait <= 1'b0;
        end else if (start && slow_start) begin
            slow_wait <= 1'b1;
        end else if (next_ack) begin
            slow_wait <= 1'b0;
        end
    end

    // Configuration register, all fields in byte lane 0
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg <= `ACQMS_CFG_RESET;
        end else if (wr_take && hit_cfg && AVS_BYTEENABLE[0]) begin
            cfg <= AVS_WRITEDATA[6:0];
        end
    end

    // Bus answer and read data
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack          <= 1'b0;
            AVS_READDATA <= 32'h00000000;
        end else begin
            ack <= next_ack;
            if (rd_take) begin
                AVS_READDATA <= rd_mux;
            end
        end
    end

    // Result bus pins, driven only for the cycle a result read answers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESULT_BUS_O  <= 12'h000;
            RESULT_BUS_OE <= 1'b0;
        end else begin
            RESULT_BUS_OE <= rd_take & hit_res;
            if (rd_take && hit_res) begin
                RESULT_BUS_O <= res_view;
            end
        end
    end

    // Selector switches, registered so analog pins never glitch
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            AIN_POS_EN    <= 8'h00;
            AIN_NEG_EN    <= 8'h00;
            COMMON_POS_EN <= 1'b0;
            COMMON_NEG_EN <= 1'b0;
            SELOUT_GND_EN <= 1'b0;
        end else begin
            AIN_POS_EN    <= sel.pos;
            AIN_NEG_EN    <= sel.neg;
            COMMON_POS_EN <= sel.com_pos;
            COMMON_NEG_EN <= sel.com_neg;
            SELOUT_GND_EN <= sel.selout_gnd;
        end
    end

    // Selector decoder
    assign sel.code = chan_code;
    assign sel.pair = pair_sel;
    acqms_chan_decode #(
        .HAS_SELOUT (HAS_SELOUT)
    ) u_decode (
        .clk   (CLK),
        .rst_n (RESET_N),
        .sel   (sel)
    );

    // Handshake and level outputs
    assign AVS_WAITREQUEST = req & ~ack;
    assign RANGE_BIPOLAR   = cfg[`ACQMS_CFG_SIGNED_BIT];
    assign HOLD            = ~idle;
    assign BUSY_N          = idle;
    // Ready falls with the slow read and rises once its answer is out
    assign READY_O         = ~(slow_rd & ~ack);
    assign READY_OE        = mode_low;

    // Helper: clock cycles a slow read has waited
    logic [CNT_W+4:0] wait_cyc;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wait_cyc <= '0;
        end else if (slow_wait) begin
            wait_cyc <= wait_cyc + 1'b1;
        end else begin
            wait_cyc <= '0;
        end
    end

    sequence s_sync_last_edge;
        (state == acqms_pkg::ACQMS_ST_SYNC) && conv_rise && (cnt == SYNC_LAST);
    endsequence

    sequence s_port_start;
        AVS_WRITE && !AVS_WAITREQUEST && hit_ctl && AVS_BYTEENABLE[0]
            && AVS_WRITEDATA[0] && idle && mode_high;
    endsequence

    // Checks on the ready pin, the sequencer, the bus answer, the result views, the range select and the code map

    ready_pin_dir_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        READY_OE == (MODE_LEVEL == 2'b00))
        else $error("ready pin direction wrong");
    port_start_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_port_start |=> (state == acqms_pkg::ACQMS_ST_SYNC) ##1 !BUSY_N)
        else $error("port write did not start conversion");
    low_write_ignored_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (idle && mode_low && AVS_WRITE && !AVS_READ) |=> idle)
        else $error("write started conversion in memory mode");
    // Open-pin timing counts system cycles, never conversion clock edges
    async_timing_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state == acqms_pkg::ACQMS_ST_ASYNC) |-> (cnt <= ASYNC_LAST)
            ##1 (idle || (cnt == $past(cnt) + 1'b1)))
        else $error("asynchronous conversion overran");
    sync_edges_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_sync_last_edge |=> idle && (result == $past(CONV_CODE_IN)))
        else $error("conversion did not end on sixteenth edge");
    sync_count_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        ((state == acqms_pkg::ACQMS_ST_SYNC) && !conv_rise) |=> (cnt == $past(cnt)))
        else $error("counter moved without a clock edge");
    slow_ready_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (slow_wait && !idle) |-> !READY_O && AVS_WAITREQUEST)
        else $error("ready high before result valid");
    // A slow read is answered only after a whole conversion has had time
    slow_answer_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (slow_wait && idle) |-> (wait_cyc > SYNC_LAST) ##1 (!AVS_WAITREQUEST && READY_O))
        else $error("slow read answered out of turn");
    upper_byte_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (rd_take && hit_res && ube) |=> RESULT_BUS_OE && (RESULT_BUS_O == {8'h00, $past(result[11:8])}))
        else $error("upper byte view wrong");
    full_word_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (rd_take && hit_res && !ube) |=> (AVS_READDATA[11:0] == $past(result)) && (RESULT_BUS_O == $past(result)))
        else $error("parallel read wrong");
    range_follow_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_take && hit_cfg && AVS_BYTEENABLE[0]) |=> RANGE_BIPOLAR == $past(AVS_WRITEDATA[4]))
        else $error("range select not applied");
    code_map_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (!pair_sel && !(chan_code[2] && chan_code[1])) |=> AIN_POS_EN == (8'h01 << $past(chan_code)))
        else $error("channel code bit order wrong");

endmodule

// file: testbench/acqms_conv_model.sv
// Converter core stand-in: free-running conversion clock and a code source.
// Assumes it shares CLK and RESET_N with the control block under test.
`timescale 1ns/100ps
module acqms_conv_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hold,
    output logic             conv_clk,
    output logic      [11:0] code
);
    logic [1:0] div;    // Divider, conversion clock is clk/4
    logic       hold_q; // Last hold level, for edge detect

    // Clock runs free; new code only when a hold begins, so it stays put
    // for the whole conversion and the capture point does not matter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div      <= 2'h0;
            conv_clk <= 1'b0;
            hold_q   <= 1'b0;
            code     <= 12'hA5C;
        end else begin
            div      <= div + 2'h1;
            conv_clk <= div[1];
            hold_q   <= hold;
            if (hold && !hold_q) begin // Fresh sample per conversion
                code <= code + 12'h6E3;
            end
        end
    end
endmodule

// file: testbench/acq_channel_mode_select_tb.sv
// Self-checking bench for the acquisition channel and mode control block.
// Assumes the converter stand-in model and the design sources are compiled first.
`timescale 1ns/100ps
module acq_channel_mode_select_tb;
    logic        CLK = 0, RESET_N = 0, AVS_READ = 0, AVS_WRITE = 0;
    logic [3:0]  AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q, r;
    logic [1:0]  MODE_LEVEL = 2'b01;        // Port mode first
    logic [11:0] code, RESULT_BUS_O, rb;
    logic [7:0]  s_pos, s_neg;
    logic        s_cpos, s_cneg, s_gnd;
    logic [7:0]  AIN_POS_EN, AIN_NEG_EN;
    logic        AVS_WAITREQUEST, cclk, cq = 0, p;
    logic        COMMON_POS_EN, COMMON_NEG_EN, SELOUT_GND_EN, RANGE_BIPOLAR;
    logic        HOLD, BUSY_N, READY_O, READY_OE, RESULT_BUS_OE;
    logic [2:0]  c;
    int          i, edges, hcyc, cyc, num_errors, comparisons;

    acqms_top #(.HAS_SELOUT(1'b0), .ASYNC_CYCLES(20)) dut_u (.CLK(CLK), .RESET_N(RESET_N),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .MODE_LEVEL(MODE_LEVEL), .CONVERSION_CLOCK_IN(cclk),
        .CONV_CODE_IN(code), .AIN_POS_EN(AIN_POS_EN), .AIN_NEG_EN(AIN_NEG_EN),
        .COMMON_POS_EN(COMMON_POS_EN), .COMMON_NEG_EN(COMMON_NEG_EN), .SELOUT_GND_EN(SELOUT_GND_EN),
        .RANGE_BIPOLAR(RANGE_BIPOLAR), .HOLD(HOLD), .BUSY_N(BUSY_N), .READY_O(READY_O),
        .READY_OE(READY_OE), .RESULT_BUS_O(RESULT_BUS_O), .RESULT_BUS_OE(RESULT_BUS_OE));
    // Selector-output variant on the same bus, for the codes it claims
    acqms_top #(.HAS_SELOUT(1'b1), .ASYNC_CYCLES(20)) sel_u (.CLK(CLK), .RESET_N(RESET_N),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(),
        .AVS_WAITREQUEST(), .MODE_LEVEL(MODE_LEVEL), .CONVERSION_CLOCK_IN(cclk),
        .CONV_CODE_IN(code), .AIN_POS_EN(s_pos), .AIN_NEG_EN(s_neg),
        .COMMON_POS_EN(s_cpos), .COMMON_NEG_EN(s_cneg), .SELOUT_GND_EN(s_gnd),
        .RANGE_BIPOLAR(), .HOLD(), .BUSY_N(), .READY_O(), .READY_OE(),
        .RESULT_BUS_O(), .RESULT_BUS_OE());
    acqms_conv_model model_u (.clk(CLK), .rst_n(RESET_N), .hold(HOLD), .conv_clk(cclk), .code(code));

    always #5 CLK = ~CLK;

    // Count conversion clock rises during hold, sampled off the edge
    always @(negedge CLK) begin
        cq <= cclk;
        if (cclk && !cq && HOLD === 1'b1) edges++;
        if (HOLD === 1'b1) hcyc++;
        // Keep what the result pins showed while driven
        if (RESULT_BUS_OE === 1'b1) rb = RESULT_BUS_O;
    end

    // Hang guard; a normal run needs well under a thousand cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon access; held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge CLK);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE     <= w;
        AVS_READ      <= !w;
        // Look mid-cycle, so the coming edge is the one that sees waitrequest low
        @(negedge CLK);
        while (AVS_WAITREQUEST !== 1'b0) @(negedge CLK);
        @(posedge CLK);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
    endtask

    // Conversion must be running now; wait until it ends
    task automatic conv();
        repeat (2) @(negedge CLK);
        chk({HOLD, BUSY_N}, 2'b10);
        while (HOLD === 1'b1) @(negedge CLK);
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        bus(0, 4'h0, 0, q);
        chk(q, 0);
        // Every code, pairing and range combination
        for (i = 0; i < 32; i++) begin
            bus(1, 4'h0, i, q);
            repeat (2) @(negedge CLK);
            c = i[2:0];
            p = i[3];
            chk({SELOUT_GND_EN, RANGE_BIPOLAR, COMMON_POS_EN, COMMON_NEG_EN, AIN_NEG_EN, AIN_POS_EN},
                {1'b0, i[4], 1'b0, !p, p ? 8'(1 << (c ^ 3'd1)) : 8'h00, 8'(1 << c)});
            chk({s_gnd, s_cpos, s_cneg, s_neg, s_pos}, (c < 3'd6) ?
                {2'b00, !p, p ? 8'(1 << (c ^ 3'd1)) : 8'h00, 8'(1 << c)} : {c == 3'd6, c == 3'd6, 1'b1, 16'h0000});
        end
        chk({READY_OE, RESULT_BUS_OE}, 2'b00);
        bus(0, 4'h2, 0, q);
        chk(q, 0);
        $display("Decode test done");
        // Port mode: start by write, full and two-byte reads
        bus(1, 4'h0, 0, q);
        edges = 0;
        bus(1, 4'h4, 1, q);
        conv();
        chk(edges >= 15 && edges <= 16, 1'b1);
        bus(0, 4'h8, 0, q);
        chk(q, 32'h16);
        bus(0, 4'hC, 0, q);
        chk(q, code);
        chk(rb, code);
        bus(1, 4'h0, 32'h20, q);
        bus(0, 4'hC, 0, q);
        chk(q[7:0], code[11:8]);
        chk(rb, {8'h00, code[11:8]});
        bus(1, 4'h0, 0, q);
        bus(0, 4'hC, 0, q);
        chk(q[11:0], code);
        $display("Port mode test done");
        // Slow memory: read stalls with ready low until result is new
        MODE_LEVEL <= 2'b00;
        r = code;
        edges = 0;
        fork
            bus(0, 4'hC, 0, q);
            begin
                repeat (4) @(negedge CLK);
                chk({READY_OE, READY_O, HOLD}, 3'b101);
            end
        join
        chk(q, code);
        chk(code !== r && edges >= 15 && edges <= 16, 1'b1);
        // ROM mode: read returns old result and starts the next one
        bus(1, 4'h0, 32'h40, q);
        r = code;
        bus(0, 4'hC, 0, q);
        chk(q, r);
        conv();
        bus(0, 4'hC, 0, q);
        chk(q, code);
        conv();
        bus(1, 4'h4, 1, q);
        repeat (3) @(negedge CLK);
        chk(HOLD, 1'b0);
        $display("Memory mode test done");
        // Open pin: conversion timed internally
        MODE_LEVEL <= 2'b10;
        hcyc = 0;
        bus(1, 4'h4, 1, q);
        conv();
        chk(hcyc, 20);
        bus(0, 4'hC, 0, q);
        chk(q, code);
        $display("Open mode test done");
        results();
    end
endmodule
